// ### dtd_pkg.sv
// package for the data-transfer opcode decoder: encodings, field positions, carrier types
`default_nettype none
package dtd_pkg;
  // opcode bytes of the decoded group
  localparam logic [7:0] DTD_OP_SEG_LOAD = 8'h8E;
  localparam logic [7:0] DTD_OP_SEG_STORE = 8'h8C;
  localparam logic [7:0] DTD_OP_TRANSLATE = 8'hD7;
  localparam logic [7:0] DTD_OP_LOAD_EA = 8'h8D;
  localparam logic [7:0] DTD_OP_LOAD_PTR_DS = 8'hC5;
  // held opcode after reset: no instruction in flight
  localparam logic [7:0] DTD_OPCODE_RESET = 8'h00;
  // addressing-mode byte field positions, plus the width bit of the opcode byte
  localparam int DTD_MOD_HI = 7;
  localparam int DTD_MOD_LO = 6;
  localparam int DTD_REG_HI = 5;
  localparam int DTD_REG_LO = 3;
  localparam int DTD_RM_HI = 2;
  localparam int DTD_RM_LO = 0;
  localparam int DTD_SEG_ZERO_BIT = 5;
  localparam int DTD_WIDTH_BIT = 0;
  localparam logic [1:0] DTD_MOD_REG = 2'h3;
  // decoded operation kinds
  typedef enum logic [5:0] {
    DTD_K_NONE = 6'h00,
    DTD_K_SEG_LOAD = 6'h01,
    DTD_K_SEG_STORE = 6'h02,
    DTD_K_TRANSLATE = 6'h04,
    DTD_K_LOAD_EA = 6'h08,
    DTD_K_LOAD_PTR = 6'h10,
    DTD_K_ILLEGAL = 6'h20
  } dtd_kind_e;
  // decoder state: waiting for opcode or for its mode byte
  typedef enum logic [1:0] {
    DTD_S_OPCODE = 2'h1,
    DTD_S_MODRM = 2'h2
  } dtd_state_e;
  // decoded instruction handed to the execution unit
  typedef struct packed {
    dtd_kind_e kind;
    logic word_wide;
    logic [1:0] mode;
    logic [2:0] reg_field;
    logic [2:0] rm_field;
    logic [1:0] seg_sel;
    logic mem_operand;
    logic dest_accumulator_low_byte;
    logic dest_data_segment_register;
  } dtd_uop_s;
  localparam dtd_uop_s DTD_UOP_RESET = '{kind: DTD_K_NONE, default: '0};
endpackage
`default_nettype wire

// ### dtd_decoder.sv
// data-transfer opcode decoder: opcode plus addressing-mode byte to decoded operation
`timescale 1ns/1ps
`default_nettype none
// Function
// - opcode 8E loads a segment register from reg/mem, with mode, zero bit, select and r/m.
// - opcode 8C is a segment-register store into reg/mem with the same mode byte layout.
// - opcode D7 is a complete one-byte translate writing the lookup byte into the low accumulator.
// - opcode 8D with mode byte writes the effective address into the register named by reg.
// - opcode C5 with mode byte loads a pointer into the named register and the data segment.
module dtd_decoder
  import dtd_pkg::*;
(
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic byte_valid_in,
  input wire logic [7:0] byte_in,
  output logic byte_ready_out,
  output var dtd_uop_s uop_out,
  output logic uop_valid_out
);
  //////////////////////////////////////////////////////////////////////////////
  dtd_state_e state_q;
  dtd_state_e state_d;
  logic [7:0] opcode_q;
  dtd_uop_s uop_q;
  dtd_uop_s uop_d;
  logic valid_q;
  logic take;

  // always ready: each byte is consumed in one cycle, no buffering
  assign byte_ready_out = 1'b1;
  assign take = byte_valid_in;

  // opcode classification, continuous for clarity
  wire is_seg_load = (byte_in == DTD_OP_SEG_LOAD);
  wire is_seg_store = (byte_in == DTD_OP_SEG_STORE);
  wire is_translate = (byte_in == DTD_OP_TRANSLATE);
  wire is_load_ea = (byte_in == DTD_OP_LOAD_EA);
  wire is_load_ptr = (byte_in == DTD_OP_LOAD_PTR_DS);
  wire needs_modrm = is_seg_load | is_seg_store | is_load_ea | is_load_ptr;
  wire [1:0] mb_mode = byte_in[DTD_MOD_HI:DTD_MOD_LO];
  wire [2:0] mb_reg = byte_in[DTD_REG_HI:DTD_REG_LO];
  wire [2:0] mb_rm = byte_in[DTD_RM_HI:DTD_RM_LO];
  wire mb_mem = (mb_mode != DTD_MOD_REG);
  wire seg_form = (opcode_q == DTD_OP_SEG_LOAD) | (opcode_q == DTD_OP_SEG_STORE);
  // segment forms need a zero bit; load-EA and load-pointer need a memory operand
  wire mb_bad = seg_form ? byte_in[DTD_SEG_ZERO_BIT] : ~mb_mem;

  // next-state and decoded word
  always_comb begin
    state_d = state_q;
    uop_d = uop_q;
    if (take) begin
      unique case (state_q)
        DTD_S_OPCODE: begin
          uop_d = DTD_UOP_RESET;
          if (needs_modrm) begin
            state_d = DTD_S_MODRM;
          end else if (is_translate) begin
            uop_d.kind = DTD_K_TRANSLATE;
            uop_d.mem_operand = 1'b1;
            uop_d.dest_accumulator_low_byte = 1'b1;
          end else begin
            uop_d.kind = DTD_K_ILLEGAL;
          end
        end
        DTD_S_MODRM: begin
          state_d = DTD_S_OPCODE;
          uop_d = DTD_UOP_RESET;
          uop_d.mode = mb_mode;
          uop_d.reg_field = mb_reg;
          uop_d.rm_field = mb_rm;
          uop_d.mem_operand = mb_mem;
          uop_d.seg_sel = mb_reg[1:0];
          // segment moves and pointer loads are word-only; the width bit picks size
          uop_d.word_wide = seg_form | opcode_q[DTD_WIDTH_BIT];
          if (mb_bad) begin
            uop_d.kind = DTD_K_ILLEGAL;
          end else if (opcode_q == DTD_OP_SEG_LOAD) begin
            uop_d.kind = DTD_K_SEG_LOAD;
          end else if (opcode_q == DTD_OP_SEG_STORE) begin
            uop_d.kind = DTD_K_SEG_STORE;
          end else if (opcode_q == DTD_OP_LOAD_EA) begin
            uop_d.kind = DTD_K_LOAD_EA;
          end else begin
            uop_d.kind = DTD_K_LOAD_PTR;
            uop_d.dest_data_segment_register = 1'b1;
          end
        end
      endcase
    end
  end

  // valid pulses when a complete instruction is decoded
  wire done = take & ((state_q == DTD_S_MODRM) | ~needs_modrm);

  // registers
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state_q <= DTD_S_OPCODE;
      opcode_q <= DTD_OPCODE_RESET;
      uop_q <= DTD_UOP_RESET;
      valid_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (take && state_q == DTD_S_OPCODE) begin
        opcode_q <= byte_in;
      end
      uop_q <= uop_d;
      valid_q <= done;
    end
  end

  assign uop_out = uop_q;
  assign uop_valid_out = valid_q;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  property p_seg_load;
    @(posedge clk_in) disable iff (srst_in)
    (take && state_q == DTD_S_OPCODE && byte_in == DTD_OP_SEG_LOAD)
      ##1 (take && !byte_in[DTD_SEG_ZERO_BIT])
      |=> (uop_valid_out && uop_out.kind == DTD_K_SEG_LOAD && uop_out.word_wide);
  endproperty
  a_seg_load: assert property (p_seg_load) else $error("segment load not decoded");
  property p_seg_store;
    @(posedge clk_in) disable iff (srst_in)
    (take && state_q == DTD_S_OPCODE && byte_in == DTD_OP_SEG_STORE) ##1 take
      |=> (uop_valid_out && uop_out.seg_sel == $past(byte_in[4:3]));
  endproperty
  a_seg_store: assert property (p_seg_store) else $error("segment select wrong");
  property p_translate;
    @(posedge clk_in) disable iff (srst_in)
    (take && state_q == DTD_S_OPCODE && byte_in == DTD_OP_TRANSLATE)
      |=> (uop_valid_out && uop_out.dest_accumulator_low_byte && state_q == DTD_S_OPCODE);
  endproperty
  a_translate: assert property (p_translate) else $error("translate not one byte");
  property p_load_ea;
    @(posedge clk_in) disable iff (srst_in)
    (take && state_q == DTD_S_OPCODE && byte_in == DTD_OP_LOAD_EA) ##1 (take && mb_mem)
      |=> (uop_out.kind == DTD_K_LOAD_EA && uop_out.reg_field == $past(byte_in[5:3]));
  endproperty
  a_load_ea: assert property (p_load_ea) else $error("load address target wrong");
  property p_load_ptr;
    @(posedge clk_in) disable iff (srst_in)
    (take && state_q == DTD_S_OPCODE && is_load_ptr) ##1 (take && mb_mem)
      |=> (uop_valid_out && uop_out.kind == DTD_K_LOAD_PTR
        && uop_out.dest_data_segment_register && uop_out.reg_field == $past(mb_reg));
  endproperty
  a_load_ptr: assert property (p_load_ptr) else $error("pointer load lacks segment");
  property p_width;
    @(posedge clk_in) disable iff (srst_in)
    (uop_valid_out && uop_out.kind == DTD_K_LOAD_EA) |-> uop_out.word_wide;
  endproperty
  a_width: assert property (p_width) else $error("width bit ignored");
  // the store form must come out as a word-wide segment store, never as a load
  property p_seg_store_kind;
    @(posedge clk_in) disable iff (srst_in)
    (take && state_q == DTD_S_OPCODE && is_seg_store)
      ##1 (take && !byte_in[DTD_SEG_ZERO_BIT])
      |=> (uop_valid_out && uop_out.kind == DTD_K_SEG_STORE && uop_out.word_wide);
  endproperty
  a_seg_store_kind: assert property (p_seg_store_kind)
    else $error("segment store not decoded");
  // a set zero bit is refused rather than read as a fifth segment number
  property p_seg_zero_bit;
    @(posedge clk_in) disable iff (srst_in)
    (take && state_q == DTD_S_OPCODE && (is_seg_load || is_seg_store))
      ##1 (take && byte_in[DTD_SEG_ZERO_BIT])
      |=> (uop_valid_out && uop_out.kind == DTD_K_ILLEGAL);
  endproperty
  a_seg_zero_bit: assert property (p_seg_zero_bit)
    else $error("segment form with bad zero bit accepted");
  // an opcode that needs a mode byte must not complete on its own
  property p_modrm_wait;
    @(posedge clk_in) disable iff (srst_in)
    (take && state_q == DTD_S_OPCODE && needs_modrm)
      |=> (!uop_valid_out && state_q == DTD_S_MODRM);
  endproperty
  a_modrm_wait: assert property (p_modrm_wait)
    else $error("mode byte not awaited");
  // a register has no effective address, so a register operand is refused
  property p_load_ea_reg_form;
    @(posedge clk_in) disable iff (srst_in)
    (take && state_q == DTD_S_OPCODE && is_load_ea) ##1 (take && !mb_mem)
      |=> (uop_valid_out && uop_out.kind == DTD_K_ILLEGAL);
  endproperty
  a_load_ea_reg_form: assert property (p_load_ea_reg_form)
    else $error("load address with register operand accepted");
  // a pointer can only come from memory; the register form is refused
  property p_ptr_reg_form;
    @(posedge clk_in) disable iff (srst_in)
    (take && state_q == DTD_S_OPCODE && is_load_ptr) ##1 (take && !mb_mem)
      |=> (uop_valid_out && uop_out.kind == DTD_K_ILLEGAL);
  endproperty
  a_ptr_reg_form: assert property (p_ptr_reg_form)
    else $error("pointer load with register operand accepted");
  // translate reads one table byte from memory into the low accumulator byte
  property p_translate_fields;
    @(posedge clk_in) disable iff (srst_in)
    (take && state_q == DTD_S_OPCODE && is_translate)
      |=> (uop_out.kind == DTD_K_TRANSLATE && uop_out.mem_operand && !uop_out.word_wide);
  endproperty
  a_translate_fields: assert property (p_translate_fields)
    else $error("translate fields wrong");
  property p_ptr_word;
    @(posedge clk_in) disable iff (srst_in)
    (uop_valid_out && uop_out.kind == DTD_K_LOAD_PTR) |-> uop_out.word_wide;
  endproperty
  a_ptr_word: assert property (p_ptr_word)
    else $error("pointer load not word wide");
  // anything outside the group is flagged in one byte so the stream stays aligned
  property p_unknown_op;
    @(posedge clk_in) disable iff (srst_in)
    (take && state_q == DTD_S_OPCODE && !needs_modrm && !is_translate)
      |=> (uop_valid_out && uop_out.kind == DTD_K_ILLEGAL);
  endproperty
  a_unknown_op: assert property (p_unknown_op)
    else $error("unknown opcode not flagged");
  // the execution unit may read the decoded word late, so it must hold between bytes
  property p_uop_holds;
    @(posedge clk_in) disable iff (srst_in)
    !take |=> $stable(uop_out);
  endproperty
  a_uop_holds: assert property (p_uop_holds)
    else $error("decoded word changed without a byte");
  // a reset in mid-instruction must leave no stale pulse and no stale kind
  property p_reset_quiet;
    @(posedge clk_in) disable iff (srst_in)
    $past(srst_in) |-> (!uop_valid_out && uop_out.kind == DTD_K_NONE);
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("decoder not quiet after reset");
endmodule
`default_nettype wire

// ### dtd_feeder.sv
// byte feeder standing in for the prefetch queue
`timescale 1ns/1ps
`default_nettype none
module dtd_feeder (
  input wire logic clk_in,
  input wire logic go_in,
  input wire logic [15:0] bytes_in,
  input wire logic two_in,
  output logic valid_out,
  output logic [7:0] byte_out
);
  logic [1:0] left_q = 2'h0;
  logic [15:0] sh_q = 16'h0000;
  // shift in the inverse so a released line never repeats the last byte
  always_ff @(posedge clk_in) begin
    if (go_in) begin
      left_q <= two_in ? 2'h2 : 2'h1;
      sh_q <= bytes_in;
    end else if (left_q != 2'h0) begin
      left_q <= left_q - 2'h1;
      sh_q <= {sh_q[7:0], ~sh_q[7:0]};
    end
  end
  assign valid_out = (left_q != 2'h0);
  assign byte_out = sh_q[15:8];
endmodule
`default_nettype wire

// ### dtd_decoder_tb.sv
// self-checking bench for the data-transfer opcode decoder
`timescale 1ns/1ps
`default_nettype none
module dtd_decoder_tb;
  import dtd_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic go = 1'b0;
  logic two = 1'b0;
  logic [15:0] bytes = 16'h0000;
  logic bv, rdy, uv;
  logic [7:0] bd;
  dtd_uop_s uop, u;
  int fails = 0;
  int n_compared = 0;
  always #20 clk = ~clk;
  dtd_feeder dtd_feeder_i (.clk_in(clk), .go_in(go), .bytes_in(bytes), .two_in(two),
    .valid_out(bv), .byte_out(bd));
  dtd_decoder dtd_decoder_i (.clk_in(clk), .srst_in(srst), .byte_valid_in(bv),
    .byte_in(bd), .byte_ready_out(rdy), .uop_out(uop), .uop_valid_out(uv));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_compared++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic results();
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // bounded wait: a missing pulse ends the run rather than hanging it
  task automatic xfer(input logic [7:0] op, input logic [7:0] mb, input logic t);
    int i;
    @(posedge clk);
    #1;
    go = 1'b1;
    bytes = {op, mb};
    two = t;
    @(posedge clk);
    #1;
    go = 1'b0;
    for (i = 0; i < 6 && uv !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    if (uv !== 1'b1) begin
      fails++;
      results();
    end else begin
      u = uop;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_seg_load();
    xfer(DTD_OP_SEG_LOAD, 8'h1E, 1'b1);
    chk(8'(u.kind), 8'(DTD_K_SEG_LOAD));
    chk(8'(u.seg_sel), 8'h03);
    chk(8'(u.rm_field), 8'h06);
    chk(8'(u.dest_accumulator_low_byte), 8'h00);
    chk(8'(u.word_wide), 8'h01);
    xfer(DTD_OP_SEG_LOAD, 8'h3E, 1'b1);
    chk(8'(u.kind), 8'(DTD_K_ILLEGAL));
    $display("seg_load done");
  endtask
  task automatic t_seg_store();
    xfer(DTD_OP_SEG_STORE, 8'hC8, 1'b1);
    chk(8'(u.kind), 8'(DTD_K_SEG_STORE));
    chk(8'(u.seg_sel), 8'h01);
    chk(8'(u.mode), 8'h03);
    chk(8'(u.mem_operand), 8'h00);
    chk(8'(u.word_wide), 8'h01);
    xfer(DTD_OP_SEG_STORE, 8'h28, 1'b1);
    chk(8'(u.kind), 8'(DTD_K_ILLEGAL));
    $display("seg_store done");
  endtask
  task automatic t_translate();
    xfer(DTD_OP_TRANSLATE, 8'h00, 1'b0);
    chk(8'(u.kind), 8'(DTD_K_TRANSLATE));
    chk(8'(u.dest_accumulator_low_byte), 8'h01);
    chk(8'(u.mem_operand), 8'h01);
    @(posedge clk);
    #1;
    chk(8'(uv), 8'h00);
    chk(8'(rdy), 8'h01);
    xfer(8'h8F, 8'h00, 1'b0);
    chk(8'(u.kind), 8'(DTD_K_ILLEGAL));
    $display("translate done");
  endtask
  task automatic t_load_ea();
    xfer(DTD_OP_LOAD_EA, 8'h46, 1'b1);
    chk(8'(u.kind), 8'(DTD_K_LOAD_EA));
    chk(8'(u.reg_field), 8'h00);
    chk(8'(u.rm_field), 8'h06);
    chk(8'(u.mode), 8'h01);
    chk(8'(u.mem_operand), 8'h01);
    chk(8'(u.dest_data_segment_register), 8'h00);
    chk(8'(u.word_wide), 8'h01);
    xfer(DTD_OP_LOAD_EA, 8'hC0, 1'b1);
    chk(8'(u.kind), 8'(DTD_K_ILLEGAL));
    $display("load_ea done");
  endtask
  task automatic t_load_ptr();
    xfer(DTD_OP_LOAD_PTR_DS, 8'h5E, 1'b1);
    chk(8'(u.kind), 8'(DTD_K_LOAD_PTR));
    chk(8'(u.reg_field), 8'h03);
    chk(8'(u.dest_data_segment_register), 8'h01);
    chk(8'(u.word_wide), 8'h01);
    xfer(DTD_OP_LOAD_PTR_DS, 8'hD8, 1'b1);
    chk(8'(u.kind), 8'(DTD_K_ILLEGAL));
    $display("load_ptr done");
  endtask
  // reset in mid-instruction: the half-taken opcode must be forgotten
  task automatic t_reset();
    @(posedge clk);
    #1;
    go = 1'b1;
    bytes = {DTD_OP_SEG_LOAD, 8'h00};
    two = 1'b0;
    @(posedge clk);
    #1;
    go = 1'b0;
    @(posedge clk);
    #1;
    srst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    srst = 1'b0;
    chk(8'(uv), 8'h00);
    chk(8'(uop.kind), 8'(DTD_K_NONE));
    xfer(DTD_OP_TRANSLATE, 8'h00, 1'b0);
    chk(8'(u.kind), 8'(DTD_K_TRANSLATE));
    $display("reset done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk);
    #1;
    srst = 1'b0;
    t_seg_load();
    t_seg_store();
    t_translate();
    t_load_ea();
    t_load_ptr();
    t_reset();
    results();
  end
endmodule
`default_nettype wire
